// *** logic/xbus_defs.vh ***
/*
  Constants for the auxiliary peripheral bus decode and glue block:
  fixed I/O ports, boot memory windows, reset values of the registered outputs.
  Assumes it is included by bare name from the design file.
*/
`ifndef XBUS_DEFS_VH
`define XBUS_DEFS_VH

// fixed I/O ports, 16-bit I/O address space
`define KBC_DATA_PORT      16'h0060
`define KBC_CMD_PORT       16'h0064
`define MCU_DATA_PORT      16'h0062
`define MCU_CMD_PORT       16'h0066

// boot memory windows, compared on address bits [23:16] of the 24-bit ISA address
`define BOOT_SEG_E_TAG     8'h0E
`define BOOT_SEG_F_TAG     8'h0F
`define BOOT_HIGH_E_TAG    8'hFE
`define BOOT_HIGH_F_TAG    8'hFF

// window enable bit positions of BOOT_RANGE_EN
`define BOOT_EN_SEG_E      0
`define BOOT_EN_SEG_F      1
`define BOOT_EN_HIGH       2

// position of the fast address-20 control in the system control port byte
`define FAST_ADDR20_BIT_BIT_POS   1

// reset values of the registered outputs and of the reset request history flop
`define ADDR20_MASK_RESET  1'b1
`define CPU_INIT_RESET     1'b0
`define KBC_CPU_RESET_REQ_N_LAST_RESET    1'b1

`endif

// *** logic/xbus_chip_select_decode.v ***
/*
  Chip select decode and glue for the auxiliary peripheral bus behind the
  ISA side of a bridge: boot memory select, keyboard controller select or
  general output, embedded microcontroller select, two programmable I/O
  selects with buffer controls, address-20 mask merge and CPU init request.
  Assumes all inputs are synchronous to CLOCK and that the ISA address and
  command qualifiers are stable while a cycle is in progress.
  The selects are combinational and may glitch while the address settles; the
  ISA command strobes qualify them, so a device only acts on a stable select.
  RST and POWER_ON_SUSPEND both force the selects to their idle level, except the keyboard pin in general output use.
*/
`timescale 1ns/1ps
`include "xbus_defs.vh"

module xbus_chip_select_decode #(
  parameter IO_ADDR_W   = 16,
  parameter RANGE_MASK_W = 8
) (
  input  wire                    CLOCK,
  input  wire                    RST,
  input  wire                    POWER_ON_SUSPEND,
  input  wire [19:0]             ISA_LATCHED_ADDR,
  input  wire [23:17]            ISA_UNLATCHED_ADDR,
  input  wire                    MEM_READ,
  input  wire                    MEM_WRITE,
  input  wire                    IO_READ,
  input  wire                    IO_WRITE,
  input  wire                    DMA_CYCLE,
  input  wire                    PCI_MASTER_CYCLE,
  input  wire [2:0]              BOOT_RANGE_EN,
  input  wire                    KBC_SELECT_AS_GPO,
  input  wire                    GENERAL_OUTPUT_26_VALUE,
  input  wire                    PROG0_ENABLE,
  input  wire [IO_ADDR_W-1:0]    PROG0_BASE,
  input  wire [RANGE_MASK_W-1:0] PROG0_MASK,
  input  wire                    PROG1_ENABLE,
  input  wire [IO_ADDR_W-1:0]    PROG1_BASE,
  input  wire [RANGE_MASK_W-1:0] PROG1_MASK,
  input  wire [7:0]              SYS_CTRL_PORT,
  input  wire                    KBC_ADDR20_GATE_IN,
  input  wire                    KBC_CPU_RESET_REQ_N,
  output wire                    BOOT_ROM_SELECT_N,
  output wire                    KEYBOARD_CTRL_SELECT_N,
  output wire                    EMBEDDED_MCU_SELECT_N,
  output wire                    PROG_IO_SELECT0_N,
  output wire                    PROG_IO_SELECT1_N,
  output wire                    AUX_BUS_BUFFER_OE_N,
  output wire                    AUX_BUS_BUFFER_DIR_N,
  output wire                    CPU_ADDR20_MASK_N,
  output wire                    CPU_INIT
);

  // the selects must follow the address with no clock delay, so they are
  // gated logic rather than flops; only the mask and init outputs are registered
  // trade-off: a flop per select would make them glitch free but would cost a
  // whole clock of decode time, which a short ISA cycle cannot spare

  localparam NUM_PROG = 2;

  wire [23:0]          full_addr;
  wire [IO_ADDR_W-1:0] io_addr;
  wire                 io_cycle;
  wire                 mem_cycle;
  wire                 quiet;
  wire                 upper_io_zero;

  assign full_addr     = {ISA_UNLATCHED_ADDR, ISA_LATCHED_ADDR[16:0]};
  assign io_addr       = ISA_LATCHED_ADDR[IO_ADDR_W-1:0];
  assign io_cycle      = IO_READ | IO_WRITE;
  assign mem_cycle     = MEM_READ | MEM_WRITE;
  // reset and suspend both park the selects; the registered outputs only obey RST
  assign quiet         = RST | POWER_ON_SUSPEND;
  // I/O space is 16 bits wide; the remaining latched and unlatched bits must be clear
  // so that a memory-like address with a matching low word never reaches a port,
  // which keeps the fixed and programmable selects out of the upper address space
  assign upper_io_zero = (ISA_LATCHED_ADDR[19:IO_ADDR_W] == {(20-IO_ADDR_W){1'b0}}) &
                         (ISA_UNLATCHED_ADDR == 7'h00);

  // boot memory select
  // each window is made of whole 64K blocks, so only the top byte of the address is compared;
  // the high window answers both blocks just under the 16M top so that the
  // reset vector and its neighbour land in the same device
  wire [7:0] addr_tag;
  wire       hit_seg_e;
  wire       hit_seg_f;
  wire       hit_high;
  wire       boot_hit;
  wire       boot_sel;

  assign addr_tag  = full_addr[23:16];
  assign hit_seg_e = BOOT_RANGE_EN[`BOOT_EN_SEG_E] & (addr_tag == `BOOT_SEG_E_TAG);
  assign hit_seg_f = BOOT_RANGE_EN[`BOOT_EN_SEG_F] & (addr_tag == `BOOT_SEG_F_TAG);
  assign hit_high  = BOOT_RANGE_EN[`BOOT_EN_HIGH] &
                     ((addr_tag == `BOOT_HIGH_E_TAG) | (addr_tag == `BOOT_HIGH_F_TAG));
  assign boot_hit  = hit_seg_e | hit_seg_f | hit_high;
  // a DMA transfer into this range targets system memory, never the boot device
  assign boot_sel  = mem_cycle & boot_hit & ~DMA_CYCLE;

  assign BOOT_ROM_SELECT_N = ~(boot_sel & ~quiet);

  // keyboard controller select or general output
  wire kbc_port;
  wire kbc_hit;
  wire kbc_sel_n;
  wire gpo_level;

  // data and command ports only; the ports in between stay undecoded here
  assign kbc_port  = (io_addr == `KBC_DATA_PORT) | (io_addr == `KBC_CMD_PORT);
  assign kbc_hit   = io_cycle & upper_io_zero & kbc_port;
  // held high in reset and suspend unless the pin is in general output use
  assign kbc_sel_n = ~(kbc_hit & ~quiet);
  // the general output is forced low in reset so the pin starts at a known level
  assign gpo_level = GENERAL_OUTPUT_26_VALUE & ~RST;

  // the mode bit is a level, so switching modes mid-cycle can glitch the pin
  assign KEYBOARD_CTRL_SELECT_N = KBC_SELECT_AS_GPO ? gpo_level : kbc_sel_n;

  // embedded microcontroller select
  wire mcu_port;
  wire mcu_hit;

  // same address qualification as the keyboard select, so both agree on I/O space
  assign mcu_port = (io_addr == `MCU_DATA_PORT) | (io_addr == `MCU_CMD_PORT);
  assign mcu_hit  = io_cycle & upper_io_zero & mcu_port;
  assign EMBEDDED_MCU_SELECT_N = ~(mcu_hit & ~quiet);

  // programmable I/O selects, one per channel
  // only cycles started by a PCI master qualify; ISA masters and DMA reach the
  // peripheral through their own decode, so the selects stay quiet for them
  // a disabled channel never selects, whatever its base and mask hold
  wire [2*IO_ADDR_W-1:0]    prog_base;
  wire [2*RANGE_MASK_W-1:0] prog_mask;
  wire [1:0]                prog_en;
  wire [1:0]                prog_sel;

  assign prog_base = {PROG1_BASE, PROG0_BASE};
  assign prog_mask = {PROG1_MASK, PROG0_MASK};
  assign prog_en   = {PROG1_ENABLE, PROG0_ENABLE};

  genvar ch;
  generate
    for (ch = 0; ch < NUM_PROG; ch = ch + 1) begin : g_prog
      // channel ch compares the I/O address with its own base under its own mask;
      // overlapping ranges are allowed and then both selects fire together
      wire [IO_ADDR_W-1:0] care;
      wire [IO_ADDR_W-1:0] base;

      // mask bits set mark low address bits ignored, giving a block of up to 2^W ports
      assign care = ~{{(IO_ADDR_W-RANGE_MASK_W){1'b0}},
                      prog_mask[ch*RANGE_MASK_W +: RANGE_MASK_W]};
      assign base = prog_base[ch*IO_ADDR_W +: IO_ADDR_W];
      assign prog_sel[ch] = prog_en[ch] & io_cycle & PCI_MASTER_CYCLE & upper_io_zero &
                            (((io_addr ^ base) & care) == {IO_ADDR_W{1'b0}}) &
                            ~quiet;
    end
  endgenerate

  // each channel drives its own pin, active low
  assign PROG_IO_SELECT0_N = ~prog_sel[0];
  assign PROG_IO_SELECT1_N = ~prog_sel[1];

  // buffer points toward the system bus on reads, toward the peripheral on writes
  // the fixed selects leave the buffer alone: those devices sit on the ISA side
  wire any_prog;
  wire prog_read;

  assign any_prog             = |prog_sel;
  // direction follows the command, so it only matters while the buffer is on
  assign prog_read            = any_prog & IO_READ;
  assign AUX_BUS_BUFFER_OE_N  = ~any_prog;
  assign AUX_BUS_BUFFER_DIR_N = ~prog_read;

  // address-20 mask and init, registered
  // both go to the processor, which expects clean levels, so they come from flops;
  // the one-cycle delay is harmless next to how slowly software toggles the gate
  // the mask resets high so line 20 passes until the gate and fast bit are both clear
  reg addr20_mask_n_reg;
  reg addr20_mask_n_next;
  reg cpu_init_reg;
  reg cpu_init_next;
  reg kbc_cpu_reset_req_n_last_reg;

  always @* begin
    // either source set lets address line 20 through
    addr20_mask_n_next = KBC_ADDR20_GATE_IN | SYS_CTRL_PORT[`FAST_ADDR20_BIT_BIT_POS];
    // one pulse per falling edge of the request, so a held request does not retrigger
    cpu_init_next      = kbc_cpu_reset_req_n_last_reg & ~KBC_CPU_RESET_REQ_N;
  end

  always @(posedge CLOCK) begin
    if (RST) begin
      addr20_mask_n_reg <= `ADDR20_MASK_RESET;
      cpu_init_reg      <= `CPU_INIT_RESET;
      kbc_cpu_reset_req_n_last_reg     <= `KBC_CPU_RESET_REQ_N_LAST_RESET;
    end else begin
      addr20_mask_n_reg <= addr20_mask_n_next;
      cpu_init_reg      <= cpu_init_next;
      kbc_cpu_reset_req_n_last_reg     <= KBC_CPU_RESET_REQ_N;
    end
  end

  // straight from the flops, no gating after them
  assign CPU_ADDR20_MASK_N = addr20_mask_n_reg;
  assign CPU_INIT          = cpu_init_reg;

endmodule

// *** tb/xbus_decode_monitor.sv ***
/* checker of the decode block; sees only the block's ports, bound below */
`timescale 1ns/1ps
`include "xbus_defs.vh"
module xbus_decode_monitor (
  input wire logic CLOCK, RST, POWER_ON_SUSPEND, IO_READ, IO_WRITE, DMA_CYCLE,
  input wire logic PCI_MASTER_CYCLE, KBC_SELECT_AS_GPO, GENERAL_OUTPUT_26_VALUE,
  input wire logic [19:0]  ISA_LATCHED_ADDR,
  input wire logic [23:17] ISA_UNLATCHED_ADDR,
  input wire logic [7:0]   SYS_CTRL_PORT,
  input wire logic KBC_ADDR20_GATE_IN, KBC_CPU_RESET_REQ_N, BOOT_ROM_SELECT_N,
  input wire logic KEYBOARD_CTRL_SELECT_N, EMBEDDED_MCU_SELECT_N, PROG_IO_SELECT0_N,
  input wire logic PROG_IO_SELECT1_N, AUX_BUS_BUFFER_OE_N, CPU_ADDR20_MASK_N, CPU_INIT,
  input wire logic AUX_BUS_BUFFER_DIR_N, PROG0_ENABLE, PROG1_ENABLE
);
  wire [15:0] port = ISA_LATCHED_ADDR[15:0];
  wire        fast = SYS_CTRL_PORT[`FAST_ADDR20_BIT_BIT_POS];
  // fixed ports only decode below 64K and outside reset or suspend
  wire        io_cmd = (IO_READ | IO_WRITE) & ~RST & ~POWER_ON_SUSPEND;
  wire        io_ok = io_cmd & ~|ISA_UNLATCHED_ADDR & ~|ISA_LATCHED_ADDR[19:16];
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_mask_merge: assert property (!$past(RST) |->
    CPU_ADDR20_MASK_N == ($past(KBC_ADDR20_GATE_IN) | $past(fast))) else $error("mask");
  a_init_pulse: assert property (!$past(RST) && $fell(KBC_CPU_RESET_REQ_N) |=>
    CPU_INIT ##1 !CPU_INIT) else $error("init pulse");
  a_init_cause: assert property (CPU_INIT && !$past(RST, 2) |->
    $past(KBC_CPU_RESET_REQ_N, 2) && !$past(KBC_CPU_RESET_REQ_N)) else $error("init cause");
  a_kbc_decode: assert property (!KBC_SELECT_AS_GPO |-> KEYBOARD_CTRL_SELECT_N ==
    !(io_ok && (port == `KBC_DATA_PORT || port == `KBC_CMD_PORT))) else $error("kbc");
  a_mcu_decode: assert property (EMBEDDED_MCU_SELECT_N ==
    !(io_ok && (port == `MCU_DATA_PORT || port == `MCU_CMD_PORT))) else $error("mcu");
  a_gpo_mode: assert property (KBC_SELECT_AS_GPO |->
    KEYBOARD_CTRL_SELECT_N == GENERAL_OUTPUT_26_VALUE) else $error("gpo");
  a_boot_dma: assert property (DMA_CYCLE |-> BOOT_ROM_SELECT_N) else $error("dma");
  a_prog_origin: assert property (!PCI_MASTER_CYCLE |->
    PROG_IO_SELECT0_N && PROG_IO_SELECT1_N) else $error("prog origin");
  a_buffer_oe: assert property (AUX_BUS_BUFFER_OE_N ==
    (PROG_IO_SELECT0_N && PROG_IO_SELECT1_N)) else $error("buffer oe");
  a_buffer_dir: assert property (AUX_BUS_BUFFER_DIR_N ==
    !(!AUX_BUS_BUFFER_OE_N && IO_READ)) else $error("buffer dir");
  a_prog_enable: assert property ((!PROG0_ENABLE |-> PROG_IO_SELECT0_N) and
    (!PROG1_ENABLE |-> PROG_IO_SELECT1_N)) else $error("prog enable");
  a_reset_high: assert property (disable iff (1'b0) RST || POWER_ON_SUSPEND |->
    BOOT_ROM_SELECT_N && EMBEDDED_MCU_SELECT_N && PROG_IO_SELECT0_N && PROG_IO_SELECT1_N)
    else $error("held high");
endmodule
bind xbus_chip_select_decode xbus_decode_monitor mon_u (.*);

// *** tb/kbc_model.sv ***
/* keyboard controller model: gate level and reset request, registered like
   the real part; assumes commands change away from the rising edge */
`timescale 1ns/1ps
module kbc_model (
  input  wire logic CLOCK,
  input  wire logic set_gate,
  input  wire logic do_reset,
  output logic      gate = 1'b0,
  output logic      kbc_cpu_reset_req_n_n = 1'b1
);
  always @(posedge CLOCK) begin
    gate <= set_gate;
    kbc_cpu_reset_req_n_n <= !do_reset;
  end
endmodule

// *** tb/testbench.sv ***
/* self-checking bench of the decode block; assumes the checker is bound */
`timescale 1ns/1ps
module testbench;
  logic CLOCK = 0, RST = 1, POWER_ON_SUSPEND = 0, MEM_READ = 0, MEM_WRITE = 0;
  logic IO_READ = 0, IO_WRITE = 0, DMA_CYCLE = 0, PCI_MASTER_CYCLE = 0;
  logic KBC_SELECT_AS_GPO = 0, GENERAL_OUTPUT_26_VALUE = 0, PROG0_ENABLE = 1, PROG1_ENABLE = 1;
  logic [19:0]  ISA_LATCHED_ADDR = 0;
  logic [23:17] ISA_UNLATCHED_ADDR = 0;
  logic [2:0]   BOOT_RANGE_EN = 0;
  logic [15:0]  PROG0_BASE = 16'h0300, PROG1_BASE = 16'h0340;
  logic [7:0]   PROG0_MASK = 8'h0F, PROG1_MASK = 8'h07, SYS_CTRL_PORT = 8'h00;
  logic         gate_cmd = 0, rst_cmd = 0;
  wire KBC_ADDR20_GATE_IN, KBC_CPU_RESET_REQ_N, BOOT_ROM_SELECT_N, KEYBOARD_CTRL_SELECT_N;
  wire EMBEDDED_MCU_SELECT_N, PROG_IO_SELECT0_N, PROG_IO_SELECT1_N, AUX_BUS_BUFFER_OE_N;
  wire AUX_BUS_BUFFER_DIR_N, CPU_ADDR20_MASK_N, CPU_INIT;
  int num_errors = 0, check_count = 0;
  logic [23:0] win [0:2] = '{24'h0E_8000, 24'h0F_0000, 24'hFF_FFFF};
  logic [15:0] ports [0:4] = '{16'h0060, 16'h0062, 16'h0064, 16'h0066, 16'h0070};
  always #10 CLOCK = ~CLOCK;
  xbus_chip_select_decode dut_u (.*);
  kbc_model kbc_u (.CLOCK(CLOCK), .set_gate(gate_cmd), .do_reset(rst_cmd),
    .gate(KBC_ADDR20_GATE_IN), .kbc_cpu_reset_req_n_n(KBC_CPU_RESET_REQ_N));
  task summarize;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic a, input logic e);
    check_count++;
    if (a !== e) begin
      num_errors++;
      $display("[FAIL] %0t output %b expected %b", $time, a, e);
    end
  endtask
  // cmd is {mem read, mem write, io read, io write}
  task put(input logic [23:0] a, input logic [3:0] cmd);
    @(negedge CLOCK);
    ISA_UNLATCHED_ADDR = a[23:17];
    ISA_LATCHED_ADDR = a[19:0];
    {MEM_READ, MEM_WRITE, IO_READ, IO_WRITE} = cmd;
    #1;
  endtask
  task t_io;
    for (int i = 0; i < 5; i++) begin
      put({8'h00, ports[i]}, i[0] ? 4'b0001 : 4'b0010);
      chk(KEYBOARD_CTRL_SELECT_N, !(ports[i] == 16'h0060 || ports[i] == 16'h0064));
      chk(EMBEDDED_MCU_SELECT_N, !(ports[i] == 16'h0062 || ports[i] == 16'h0066));
    end
    put(24'h02_0060, 4'b0010);
    chk(KEYBOARD_CTRL_SELECT_N, 1'b1);
  endtask
  task t_boot;
    for (int e = 0; e < 3; e++) begin
      BOOT_RANGE_EN = 3'h1 << e;
      for (int j = 0; j < 3; j++) begin
        put(win[j], j[0] ? 4'b0100 : 4'b1000);
        chk(BOOT_ROM_SELECT_N, j != e);
      end
      DMA_CYCLE = 1;
      put(win[e], 4'b1000);
      chk(BOOT_ROM_SELECT_N, 1'b1);
      DMA_CYCLE = 0;
    end
  endtask
  task t_prog;
    PCI_MASTER_CYCLE = 1;
    put(24'h00_030A, 4'b0010);
    chk(PROG_IO_SELECT0_N, 1'b0);
    chk(PROG_IO_SELECT1_N, 1'b1);
    chk(AUX_BUS_BUFFER_OE_N, 1'b0);
    chk(AUX_BUS_BUFFER_DIR_N, 1'b0);
    put(24'h00_0345, 4'b0001);
    chk(PROG_IO_SELECT1_N, 1'b0);
    chk(AUX_BUS_BUFFER_DIR_N, 1'b1);
    PCI_MASTER_CYCLE = 0;
    put(24'h00_030A, 4'b0010);
    chk(PROG_IO_SELECT0_N, 1'b1);
    chk(AUX_BUS_BUFFER_OE_N, 1'b1);
    PCI_MASTER_CYCLE = 1;
    PROG0_ENABLE = 0;
    put(24'h00_030A, 4'b0010);
    chk(PROG_IO_SELECT0_N, 1'b1);
    chk(AUX_BUS_BUFFER_OE_N, 1'b1);
    PROG0_ENABLE = 1;
    PCI_MASTER_CYCLE = 0;
  endtask
  task t_reset;
    @(negedge CLOCK);
    gate_cmd = 0;
    SYS_CTRL_PORT = 8'h00;
    BOOT_RANGE_EN = 3'h2;
    repeat (2) @(posedge CLOCK);
    #1 chk(CPU_ADDR20_MASK_N, 1'b0);
    put(24'h0F_0000, 4'b1000);
    chk(BOOT_ROM_SELECT_N, 1'b0);
    @(negedge CLOCK) RST = 1;
    #1 chk(BOOT_ROM_SELECT_N, 1'b1);
    @(posedge CLOCK) #1 chk(CPU_ADDR20_MASK_N, 1'b1);
    @(negedge CLOCK) RST = 0;
    POWER_ON_SUSPEND = 1;
    #1 chk(BOOT_ROM_SELECT_N, 1'b1);
    repeat (2) @(posedge CLOCK);
    #1 chk(CPU_ADDR20_MASK_N, 1'b0);
    @(negedge CLOCK) POWER_ON_SUSPEND = 0;
    #1 chk(BOOT_ROM_SELECT_N, 1'b0);
    put(24'h00_0000, 4'b0000);
    BOOT_RANGE_EN = 3'h0;
  endtask
  task t_a20;
    for (int i = 0; i < 4; i++) begin
      @(negedge CLOCK);
      gate_cmd = i[0];
      SYS_CTRL_PORT = i[1] ? 8'h02 : 8'hFD;
      repeat (2) @(posedge CLOCK);
      #1 chk(CPU_ADDR20_MASK_N, i[0] | i[1]);
    end
  endtask
  task t_misc;
    @(negedge CLOCK) rst_cmd = 1;
    @(negedge CLOCK) rst_cmd = 0;
    @(posedge CLOCK) #1 chk(CPU_INIT, 1'b1);
    @(posedge CLOCK) #1 chk(CPU_INIT, 1'b0);
    KBC_SELECT_AS_GPO = 1;
    put(24'h00_0060, 4'b0010);
    chk(KEYBOARD_CTRL_SELECT_N, 1'b0);
    @(negedge CLOCK) GENERAL_OUTPUT_26_VALUE = 1;
    #1 chk(KEYBOARD_CTRL_SELECT_N, 1'b1);
    KBC_SELECT_AS_GPO = 0;
    POWER_ON_SUSPEND = 1;
    put(24'h00_0062, 4'b0010);
    chk(EMBEDDED_MCU_SELECT_N, 1'b1);
    @(negedge CLOCK) POWER_ON_SUSPEND = 0;
    #1 chk(EMBEDDED_MCU_SELECT_N, 1'b0);
  endtask
  initial begin
    put(24'h00_0062, 4'b0010);
    chk(EMBEDDED_MCU_SELECT_N, 1'b1);
    repeat (5) @(negedge CLOCK);
    RST = 0;
    t_io();
    t_boot();
    t_prog();
    t_a20();
    t_misc();
    t_reset();
    summarize();
  end
  // the whole run is about 50 cycles
  initial begin
    #20000;
    num_errors++;
    summarize();
  end
endmodule
